// *** src/dsu_status_pkg.sv ***
package dsu_status_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] SELFTEST_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;
  localparam logic [7:0] BPV_CNT_OFS  = 8'h0c;
  localparam logic [7:0] LAMPS_OFS    = 8'h10;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields
  localparam int unsigned CTRL_W         = 11;
  localparam int unsigned CTRL_RATE64    = 0;
  localparam int unsigned CTRL_CRIT_LO   = 1;
  localparam int unsigned CTRL_SESSION   = 3;
  localparam int unsigned CTRL_AWAIT_CFG = 4;
  localparam int unsigned CTRL_DOWNLOAD  = 5;
  localparam int unsigned CTRL_LOC_LOOP  = 6;
  localparam int unsigned CTRL_REM_LOOP  = 7;
  localparam int unsigned CTRL_TEST_CODE = 8;
  localparam int unsigned CTRL_BERT      = 9;
  localparam int unsigned CTRL_CTS_EN    = 10;
  localparam logic [10:0] CTRL_RESET     = 11'h000;

  // Self-test register fields
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_PASS = 1;

  // Port-loss criterion encodings
  localparam logic [1:0] CRIT_NONE = 2'h0;
  localparam logic [1:0] CRIT_DTR  = 2'h1;
  localparam logic [1:0] CRIT_RTS  = 2'h2;
  localparam logic [1:0] CRIT_BOTH = 2'h3;

  // Highest active alarm, high to low priority
  localparam logic [2:0] TOP_NONE = 3'h0;
  localparam logic [2:0] TOP_LOS  = 3'h1;
  localparam logic [2:0] TOP_OOF  = 3'h2;
  localparam logic [2:0] TOP_CTL  = 3'h3;
  localparam logic [2:0] TOP_BPV  = 3'h4;

  // Status register field positions
  localparam int unsigned STAT_TOP_LO = 8;

  // Framing and counting
  localparam logic [2:0]  OOF_ERR_LIMIT = 3'h5;
  localparam logic [15:0] BPV_MAX       = 16'hffff;

  // Timing
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned LOS_TIME_US   = 100;
  localparam int unsigned LOS_CYCLES    = LOS_TIME_US * CLK_MHZ;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_CYCLES  = BLINK_HALF_MS * 1000 * CLK_MHZ;

endpackage

// *** src/dsu_alarm_led_status.sv ***
`timescale 1ns/1ps

module dsu_alarm_led_status #(
  parameter int unsigned LOS_CYCLES   = dsu_status_pkg::LOS_CYCLES,
  parameter int unsigned BLINK_CYCLES = dsu_status_pkg::BLINK_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins
  input  wire logic        power_good,
  input  wire logic        line_rx_pos,
  input  wire logic        line_rx_neg,
  input  wire logic        rts_in,
  input  wire logic        dtr_in,
  // Framing and code recovery, same clock
  input  wire logic        faw_check,
  input  wire logic        faw_error,
  input  wire logic        faw_locked,
  input  wire logic        ctl_code_seen,
  input  wire logic        flag_seen,
  input  wire logic        line_tx_active,
  // DTE handshake and lamps
  output logic             cts_out,
  output logic             power_lamp,
  output logic             download_fail_lamp,
  output logic             line_alarm_lamp,
  output logic             line_traffic_lamp,
  output logic             test_lamp,
  output logic             tx_handshake_lamp,
  output logic             rx_handshake_lamp
);

  localparam int unsigned NSYNC = 5;

  logic [NSYNC-1:0]  sync_a;
  logic [NSYNC-1:0]  sync_b;
  logic              pos_prev;
  logic              neg_prev;
  logic              pos_pulse;
  logic              neg_pulse;
  logic              last_pol_pos;
  logic              pol_known;
  logic              bpv_pulse;
  logic [15:0]       bpv_count;
  logic [14:0]       quiet_cnt;
  logic              los;
  logic [2:0]        faw_err_run;
  logic              oof;
  logic              ctl_alarm;
  logic              oof_rep;
  logic              ctl_rep;
  logic              net_alarm;
  logic              dp_loss;
  logic [2:0]        top_alarm;
  logic [25:0]       blink_cnt;
  logic              blink;
  logic [10:0]       ctrl;
  logic              st_done;
  logic              st_pass;
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic [31:0]       wmask;
  logic [31:0]       rd_mux;
  logic              rd_ok;
  logic [1:0]        crit;
  logic              rate64;
  logic              sync_rts;
  logic              sync_dtr;
  logic              testing;
  logic              next_power_lamp;
  logic              next_fail_lamp;
  logic              next_test_lamp;
  logic              next_cts;

  assign crit     = ctrl[dsu_status_pkg::CTRL_CRIT_LO +: 2];
  assign rate64   = ctrl[dsu_status_pkg::CTRL_RATE64];
  assign sync_rts = sync_b[3];
  assign sync_dtr = sync_b[4];

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {dtr_in, rts_in, line_rx_neg, line_rx_pos, power_good};
      sync_b <= sync_a;
    end
  end

  // Rising edges of the line pulse rails
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_prev <= 1'b0;
      neg_prev <= 1'b0;
    end else begin
      pos_prev <= sync_b[1];
      neg_prev <= sync_b[2];
    end
  end
  assign pos_pulse = sync_b[1] & ~pos_prev;
  assign neg_pulse = sync_b[2] & ~neg_prev;

  // Polarity tracker; a pulse repeating the last polarity is a violation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_pol_pos <= 1'b0;
      pol_known    <= 1'b0;
    end else if (pos_pulse ^ neg_pulse) begin
      last_pol_pos <= pos_pulse;
      pol_known    <= 1'b1;
    end
  end
  assign bpv_pulse = pol_known & (pos_pulse ^ neg_pulse)
                   & (pos_pulse == last_pol_pos);

  // Violation counter saturates; a clearing write in the cycle of a new violation leaves a count of one
  always_ff @(posedge aclk) begin
    if (!aresetn || !st_done) begin
      bpv_count <= '0;
    end else if (do_write && aw_addr == dsu_status_pkg::BPV_CNT_OFS) begin
      bpv_count <= {15'h0000, bpv_pulse};
    end else if (bpv_pulse && bpv_count != dsu_status_pkg::BPV_MAX) begin
      bpv_count <= bpv_count + 16'h0001;
    end
  end

  // Loss of signal after a quiet stretch with no pulses at all
  always_ff @(posedge aclk) begin
    if (!aresetn || !st_done) begin
      quiet_cnt <= '0;
      los       <= 1'b0;
    end else if (pos_pulse || neg_pulse) begin
      quiet_cnt <= '0;
      los       <= 1'b0;
    end else if (quiet_cnt == 15'(LOS_CYCLES - 1)) begin
      los       <= 1'b1;
    end else begin
      quiet_cnt <= quiet_cnt + 15'h0001;
    end
  end

  // Out-of-frame on a run of errored alignment words, cleared on lock
  always_ff @(posedge aclk) begin
    if (!aresetn || !st_done) begin
      faw_err_run <= '0;
      oof         <= 1'b0;
    end else if (faw_locked) begin
      faw_err_run <= '0;
      oof         <= 1'b0;
    end else if (faw_check && !faw_error) begin
      faw_err_run <= '0;
    end else if (faw_check && faw_error) begin
      if (faw_err_run == dsu_status_pkg::OOF_ERR_LIMIT - 3'h1) begin
        oof <= 1'b1;
      end else begin
        faw_err_run <= faw_err_run + 3'h1;
      end
    end
  end

  // Control code held while received; flag characters never count
  always_ff @(posedge aclk) begin
    if (!aresetn || !st_done) begin
      ctl_alarm <= 1'b0;
    end else begin
      ctl_alarm <= ctl_code_seen & ~flag_seen;
    end
  end

  // Mode gating and ranking of network alarms
  assign oof_rep   = oof & rate64;
  assign ctl_rep   = ctl_alarm & ~rate64;
  assign net_alarm = los | oof_rep | ctl_rep;

  always_comb begin
    if (los) begin
      top_alarm = dsu_status_pkg::TOP_LOS;
    end else if (oof_rep) begin
      top_alarm = dsu_status_pkg::TOP_OOF;
    end else if (ctl_rep) begin
      top_alarm = dsu_status_pkg::TOP_CTL;
    end else if (bpv_count != 16'h0000) begin
      top_alarm = dsu_status_pkg::TOP_BPV;
    end else begin
      top_alarm = dsu_status_pkg::TOP_NONE;
    end
  end

  // Data port loss per the selected criterion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dp_loss <= 1'b0;
    end else begin
      unique case (crit)
        dsu_status_pkg::CRIT_NONE: dp_loss <= 1'b0;
        dsu_status_pkg::CRIT_DTR:  dp_loss <= ~sync_dtr;
        dsu_status_pkg::CRIT_RTS:  dp_loss <= ~sync_rts;
        dsu_status_pkg::CRIT_BOTH: dp_loss <= ~sync_dtr | ~sync_rts;
      endcase
    end
  end

  // One shared blink phase, so power and test lamps blink in step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt <= '0;
      blink     <= 1'b0;
    end else if (blink_cnt == 26'(BLINK_CYCLES - 1)) begin
      blink_cnt <= '0;
      blink     <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 26'h0000001;
    end
  end

  // Write path: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held       <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held       <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}},
                     {8{w_strb[1]}}, {8{w_strb[0]}}};

  // Write response; unmapped or read-only offsets answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dsu_status_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == dsu_status_pkg::CTRL_OFS ||
          aw_addr == dsu_status_pkg::SELFTEST_OFS ||
          aw_addr == dsu_status_pkg::BPV_CNT_OFS) begin
        s_axi_bresp <= dsu_status_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= dsu_status_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= dsu_status_pkg::CTRL_RESET;
    end else if (do_write && aw_addr == dsu_status_pkg::CTRL_OFS) begin
      ctrl <= (ctrl & ~wmask[10:0]) | (w_data[10:0] & wmask[10:0]);
    end
  end

  // Self-test result, posted by the local processor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_done <= 1'b0;
      st_pass <= 1'b0;
    end else if (do_write && aw_addr == dsu_status_pkg::SELFTEST_OFS
                 && w_strb[0]) begin
      st_done <= w_data[dsu_status_pkg::ST_DONE];
      st_pass <= w_data[dsu_status_pkg::ST_PASS];
    end
  end

  // Read data selection
  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      dsu_status_pkg::CTRL_OFS: begin
        rd_mux[10:0] = ctrl;
      end
      dsu_status_pkg::SELFTEST_OFS: begin
        rd_mux[dsu_status_pkg::ST_DONE] = st_done;
        rd_mux[dsu_status_pkg::ST_PASS] = st_pass;
      end
      dsu_status_pkg::STATUS_OFS: begin
        rd_mux[4:0] = {bpv_count != 16'h0000, dp_loss, ctl_rep,
                       oof_rep, los};
        rd_mux[dsu_status_pkg::STAT_TOP_LO +: 3] = top_alarm;
      end
      dsu_status_pkg::BPV_CNT_OFS: begin
        rd_mux[15:0] = bpv_count;
      end
      dsu_status_pkg::LAMPS_OFS: begin
        rd_mux[7:0] = {cts_out, rx_handshake_lamp, tx_handshake_lamp,
                       test_lamp, line_traffic_lamp, line_alarm_lamp,
                       download_fail_lamp, power_lamp};
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read path answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= dsu_status_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? dsu_status_pkg::RESP_OKAY
                             : dsu_status_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Lamp decisions; power loss darkens only the power lamp
  assign testing = ctrl[dsu_status_pkg::CTRL_LOC_LOOP]
                 | ctrl[dsu_status_pkg::CTRL_REM_LOOP]
                 | ctrl[dsu_status_pkg::CTRL_TEST_CODE]
                 | ctrl[dsu_status_pkg::CTRL_BERT];

  always_comb begin
    next_power_lamp = 1'b0;
    if (sync_b[0] && st_done && st_pass) begin
      if (ctrl[dsu_status_pkg::CTRL_SESSION] ||
          ctrl[dsu_status_pkg::CTRL_AWAIT_CFG]) begin
        next_power_lamp = blink;
      end else begin
        next_power_lamp = 1'b1;
      end
    end
  end

  always_comb begin
    if (ctrl[dsu_status_pkg::CTRL_DOWNLOAD]) begin
      next_fail_lamp = blink;
    end else begin
      next_fail_lamp = st_done & ~st_pass;
    end
  end

  always_comb begin
    if (testing) begin
      next_test_lamp = 1'b1;
    end else if (ctrl[dsu_status_pkg::CTRL_AWAIT_CFG]) begin
      next_test_lamp = blink;
    end else begin
      next_test_lamp = 1'b0;
    end
  end

  // Clear-to-send drops during network alarms
  assign next_cts = ctrl[dsu_status_pkg::CTRL_CTS_EN] & ~net_alarm;

  // All lamp outputs registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_lamp         <= 1'b0;
      download_fail_lamp <= 1'b0;
      line_alarm_lamp    <= 1'b0;
      line_traffic_lamp  <= 1'b0;
      test_lamp          <= 1'b0;
      tx_handshake_lamp  <= 1'b0;
      rx_handshake_lamp  <= 1'b0;
      cts_out            <= 1'b0;
    end else begin
      power_lamp         <= next_power_lamp;
      download_fail_lamp <= next_fail_lamp;
      line_alarm_lamp    <= net_alarm;
      line_traffic_lamp  <= ~net_alarm & st_done
                          & (pos_pulse | neg_pulse | pos_prev | neg_prev
                             | (quiet_cnt != '0) | line_tx_active);
      test_lamp          <= next_test_lamp;
      cts_out            <= next_cts;
      tx_handshake_lamp  <= next_cts;
      rx_handshake_lamp  <= sync_rts
                          | crit == dsu_status_pkg::CRIT_NONE
                          | crit == dsu_status_pkg::CRIT_DTR;
    end
  end

endmodule

// *** tb/dsu_status_props.sv ***
`timescale 1ns/1ps

// Port-level timing of lamps, handshake and bus answers
module dsu_status_props #(
  parameter int unsigned LOS_CYCLES   = 20,
  parameter int unsigned BLINK_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic power_good,
  input wire logic rts_in,
  input wire logic cts_out,
  input wire logic power_lamp,
  input wire logic download_fail_lamp,
  input wire logic line_alarm_lamp,
  input wire logic line_traffic_lamp,
  input wire logic test_lamp,
  input wire logic tx_handshake_lamp,
  input wire logic rx_handshake_lamp
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Reset is the cause here, so it cannot also disable the check
  property p_reset_dark;
    disable iff (1'b0)
    !aresetn |=> !(power_lamp || download_fail_lamp || line_alarm_lamp
      || line_traffic_lamp || test_lamp || cts_out);
  endproperty
  a_reset_dark: assert property (p_reset_dark)
    else $error("lamp lit straight after reset");

  property p_tx_follow;
    $changed(cts_out) |-> ##[0:1] (tx_handshake_lamp == cts_out);
  endproperty
  a_tx_follow: assert property (p_tx_follow)
    else $error("transmit lamp does not follow clear to send");

  // Two cycles of alarm, though both lamps are set from net_alarm in the same register stage
  property p_traffic_off;
    line_alarm_lamp [*2] |-> !line_traffic_lamp;
  endproperty
  a_traffic_off: assert property (p_traffic_off)
    else $error("traffic lamp lit during line alarm");

  property p_cts_alarm;
    line_alarm_lamp [*2] |-> !cts_out;
  endproperty
  a_cts_alarm: assert property (p_cts_alarm)
    else $error("clear to send held during line alarm");

  // Five cycles cover the two sync stages and the lamp register
  property p_power_off;
    !power_good [*5] |-> !power_lamp;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("power lamp lit without power");

  property p_rts_lamp;
    rts_in [*5] |-> rx_handshake_lamp;
  endproperty
  a_rts_lamp: assert property (p_rts_lamp)
    else $error("receive lamp dark with request to send high");

  property p_b_answer;
    s_axi_awvalid && s_axi_awready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write response late");

  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
endmodule

bind dsu_alarm_led_status dsu_status_props #(
  .LOS_CYCLES(LOS_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)
) dsu_status_props_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .power_good(power_good), .rts_in(rts_in),
  .cts_out(cts_out), .power_lamp(power_lamp),
  .download_fail_lamp(download_fail_lamp),
  .line_alarm_lamp(line_alarm_lamp),
  .line_traffic_lamp(line_traffic_lamp), .test_lamp(test_lamp),
  .tx_handshake_lamp(tx_handshake_lamp),
  .rx_handshake_lamp(rx_handshake_lamp)
);

// *** tb/line_model.sv ***
`timescale 1ns/1ps

// Office side of the line: alternating pulses, control code when idle
module line_model (
  input  wire logic aclk,
  input  wire logic run,
  input  wire logic idle,
  input  wire logic bpv,
  output logic      pos,
  output logic      neg,
  output logic      ctl
);
  logic [1:0] ph  = 2'h0;
  logic       pol = 1'b0;

  // One pulse every four cycles; a stopped line shows no pulses at all
  always_ff @(posedge aclk) begin
    ph <= ph + 2'h1;
    pos <= 1'b0;
    neg <= 1'b0;
    if (run && ph == 2'h0) begin
      pos <= pol;
      neg <= ~pol;
      if (!bpv) begin
        pol <= ~pol;
      end
    end
  end

  // Code is repeated for as long as the office stays idle
  always_ff @(posedge aclk) begin
    ctl <= idle;
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps

module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0, pg = 1'b1, rts = 1'b1;
  logic        brdy = 1'b0, rrdy = 1'b0, dtr = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, fc = 1'b0, fe = 1'b0;
  logic        fl = 1'b0, flag = 1'b0, run = 1'b1, idle = 1'b0, bpv = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd_d, rdat;
  logic [1:0]  br, rr, rsp;
  logic        awr, wrr, bv, arr, rv, cts, lp, lf, la, lt, lts, ltx, lrx;
  logic        pos, neg, ctl;
  logic [19:0] row;
  int          num_errors = 0, samples_checked = 0;
  // Rows: control word, request to send, expected lamp word
  localparam logic [19:0] rows [9] = '{20'h801e9, 20'h08159, 20'h10159,
    20'h20159, 20'h40159, 20'h808a9, 20'h80ca9, 20'h804e9, 20'h800e9};

  always #2.5 aclk = ~aclk;

  dsu_alarm_led_status #(.LOS_CYCLES(20), .BLINK_CYCLES(8))
  dsu_alarm_led_status_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .power_good(pg), .line_rx_pos(pos),
    .line_rx_neg(neg), .rts_in(rts), .dtr_in(dtr), .faw_check(fc),
    .faw_error(fe), .faw_locked(fl), .ctl_code_seen(ctl),
    .flag_seen(flag), .line_tx_active(1'b0), .cts_out(cts),
    .power_lamp(lp), .download_fail_lamp(lf), .line_alarm_lamp(la),
    .line_traffic_lamp(lt), .test_lamp(lts), .tx_handshake_lamp(ltx),
    .rx_handshake_lamp(lrx));

  line_model line_model_inst (.aclk(aclk), .run(run), .idle(idle),
    .bpv(bpv), .pos(pos), .neg(neg), .ctl(ctl));

  task end_of_test;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      // Response ready raised once the address is taken, held until answer
      if (awv && awr) begin
        awv <= 1'b0;
        brdy <= 1'b1;
      end
      if (wv && wrr) wv <= 1'b0;
      if (bv) begin
        rsp = br;
        brdy <= 1'b0;
        break;
      end
    end
    if (n == 60) begin
      num_errors++;
      end_of_test();
    end
  endtask

  task rd(input logic [7:0] a);
    int n;
    ara <= a;
    arv <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (arv && arr) begin
        arv <= 1'b0;
        rrdy <= 1'b1;
      end
      if (rv) begin
        rdat = rd_d;
        rsp = rr;
        rrdy <= 1'b0;
        break;
      end
    end
    if (n == 60) begin
      num_errors++;
      end_of_test();
    end
  endtask

  // Loss, out-of-frame and control alarm bits and top alarm field only
  task st(input logic [31:0] e);
    rd(dsu_status_pkg::STATUS_OFS);
    chk("status", rdat & 32'h707, e);
  endtask

  task faw(input logic e);
    fc <= 1'b1;
    fe <= e;
    @(posedge aclk);
    fc <= 1'b0;
    @(posedge aclk);
  endtask

  task lock;
    fl <= 1'b1;
    @(posedge aclk);
    fl <= 1'b0;
    tick(4);
  endtask

  // 32 cycles at a half period of 8 hold exactly four toggles
  task blink(input logic [31:0] c, input int ep, input int ef, input int ed);
    int np, nf, nd;
    logic p, f;
    wr(dsu_status_pkg::CTRL_OFS, c);
    tick(4);
    #1;
    np = 0;
    nf = 0;
    nd = 0;
    p = lp;
    f = lf;
    repeat (32) begin
      @(posedge aclk);
      #1;
      np += int'(lp !== p);
      nf += int'(lf !== f);
      nd += int'(lts !== lp);
      p = lp;
      f = lf;
    end
    chk("power toggles", np, ep);
    chk("fail toggles", nf, ef);
    chk("test against power", nd, ed);
  endtask

  initial begin
    tick(8);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("fail lamp", lf, 32'h0);
    rd(dsu_status_pkg::CTRL_OFS);
    chk("control reset", rdat, 32'h0);
    // Alarms must stay quiet before the self-test result
    run <= 1'b0;
    tick(40);
    st(32'h0);
    run <= 1'b1;
    wr(dsu_status_pkg::SELFTEST_OFS, 32'h1);
    tick(8);
    chk("fail lamp", lf, 32'h1);
    chk("power lamp", lp, 32'h0);
    wr(dsu_status_pkg::SELFTEST_OFS, 32'h3);
    tick(8);
    for (int i = 0; i < 9; i++) begin
      row = rows[i];
      rts <= row[8];
      wr(dsu_status_pkg::CTRL_OFS, 32'(row[19:9]));
      tick(8);
      rd(dsu_status_pkg::LAMPS_OFS);
      chk("lamps", rdat, 32'(row[7:0]));
    end
    rts <= 1'b1;
    // Terminal ready dropped while it is the monitored line
    dtr <= 1'b0;
    wr(dsu_status_pkg::CTRL_OFS, 32'h002);
    tick(8);
    rd(dsu_status_pkg::STATUS_OFS);
    chk("port loss", rdat & 32'h8, 32'h8);
    dtr <= 1'b1;
    blink(32'h018, 4, 0, 0);
    blink(32'h020, 0, 4, 32);
    // A good word in the run restarts the count of errored words
    wr(dsu_status_pkg::CTRL_OFS, 32'h401);
    repeat (4) faw(1'b1);
    faw(1'b0);
    repeat (4) faw(1'b1);
    tick(4);
    st(32'h0);
    faw(1'b1);
    tick(4);
    st(32'h202);
    chk("alarm lamp", la, 32'h1);
    chk("traffic lamp", lt, 32'h0);
    lock();
    st(32'h0);
    wr(dsu_status_pkg::CTRL_OFS, 32'h400);
    repeat (5) faw(1'b1);
    tick(4);
    st(32'h0);
    chk("alarm lamp", la, 32'h0);
    lock();
    idle <= 1'b1;
    tick(6);
    st(32'h304);
    flag <= 1'b1;
    tick(6);
    st(32'h0);
    flag <= 1'b0;
    wr(dsu_status_pkg::CTRL_OFS, 32'h401);
    tick(6);
    st(32'h0);
    wr(dsu_status_pkg::CTRL_OFS, 32'h400);
    run <= 1'b0;
    tick(40);
    st(32'h105);
    run <= 1'b1;
    idle <= 1'b0;
    tick(8);
    st(32'h0);
    wr(dsu_status_pkg::BPV_CNT_OFS, 32'h0);
    bpv <= 1'b1;
    tick(4);
    bpv <= 1'b0;
    tick(8);
    rd(dsu_status_pkg::BPV_CNT_OFS);
    chk("violation count", rdat, 32'h1);
    st(32'h400);
    wr(dsu_status_pkg::BPV_CNT_OFS, 32'h0);
    rd(dsu_status_pkg::BPV_CNT_OFS);
    chk("violation count", rdat, 32'h0);
    rd(8'h14);
    chk("unmapped data", rdat, 32'h0);
    chk("unmapped resp", 32'(rsp), 32'(dsu_status_pkg::RESP_SLVERR));
    wr(dsu_status_pkg::STATUS_OFS, 32'h1);
    chk("read-only resp", 32'(rsp), 32'(dsu_status_pkg::RESP_SLVERR));
    pg <= 1'b0;
    tick(8);
    chk("power lamp", lp, 32'h0);
    end_of_test();
  end
endmodule
